// ### rtl/cci_exec.sv
// single-cycle execution of the clear and complement instructions
// What this block does
// - file-clear opcode writes zero to the addressed file register and sets zero flag.
// - accumulator-clear opcode loads zero into the accumulator and sets zero flag.
// - complement opcode inverts the file value; zero flag reflects the inverted result.
// - complement destination bit 0 writes accumulator, bit 1 writes file register.
`timescale 1ns/1ps
module cci_exec
   import cci_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic INSTR_VALID,
   input wire logic [13:0] INSTR,
   input wire logic [7:0] FILE_RDATA,
   output logic [6:0] FILE_RADDR,
   output logic INSTR_HIT,
   output logic FILE_WE,
   output logic [6:0] FILE_WADDR,
   output logic [7:0] FILE_WDATA,
   output logic ACC_WE,
   output logic [7:0] ACC_WDATA,
   output logic ZERO_WE,
   output logic ZERO_VAL
);
   // operation decoded from the word presented this cycle
   cci_op_t op;
   // registered write-back stage and its next value
   cci_wb_t wb_ff;
   cci_wb_t nxt_wb;
   // candidate write-backs, one for each outcome
   cci_wb_t wb_idle;
   cci_wb_t wb_fclr;
   cci_wb_t wb_aclr;
   cci_wb_t wb_fcom;
   // operand path
   logic [CCI_ADDR_W-1:0] file_sel;
   logic [CCI_DATA_W-1:0] operand;
   wire logic [CCI_DATA_W-1:0] inverted;
   logic dest_bit;
   logic inv_is_zero;
   // opcode matches, each qualified by the valid strobe
   logic hit_fclr;
   logic hit_aclr;
   logic hit_fcom;

   // operand fields of the instruction word
   function automatic logic [CCI_ADDR_W-1:0] addr_field(
      input logic [CCI_INSTR_W-1:0] word
   );
      addr_field = word[CCI_ADDR_W-1:0];
   endfunction

   function automatic logic dest_field(
      input logic [CCI_INSTR_W-1:0] word
   );
      dest_field = word[CCI_DEST_BIT];
   endfunction

   // masked compare shared by the two opcodes that carry a file address
   function automatic logic match_masked(
      input logic [CCI_INSTR_W-1:0] word,
      input logic [CCI_INSTR_W-1:0] mask,
      input logic [CCI_INSTR_W-1:0] pattern
   );
      match_masked = ((word & mask) == pattern);
   endfunction

   // exact compare for the opcode without an operand field
   function automatic logic match_exact(
      input logic [CCI_INSTR_W-1:0] word,
      input logic [CCI_INSTR_W-1:0] pattern
   );
      match_exact = (word == pattern);
   endfunction

   function automatic logic byte_is_zero(
      input logic [CCI_DATA_W-1:0] value
   );
      byte_is_zero = (value == CCI_ZERO_BYTE);
   endfunction

   // patterns are disjoint, so the priority order is only a tie-break
   function automatic cci_op_t encode_op(
      input logic is_fclr,
      input logic is_aclr,
      input logic is_fcom
   );
      if (is_fclr) begin
         encode_op = CCI_OP_FCLR;
      end else if (is_aclr) begin
         encode_op = CCI_OP_ACLR;
      end else if (is_fcom) begin
         encode_op = CCI_OP_FCOM;
      end else begin
         encode_op = CCI_OP_NONE;
      end
   endfunction

   // nothing written; the address still follows the word, which is harmless
   function automatic cci_wb_t build_idle(
      input logic [CCI_ADDR_W-1:0] addr
   );
      cci_wb_t wb;
      wb = '0;
      wb.file_addr = addr;
      build_idle = wb;
   endfunction

   function automatic cci_wb_t build_fclr(
      input logic [CCI_ADDR_W-1:0] addr
   );
      cci_wb_t wb;
      wb = '0;
      wb.file_addr = addr;
      wb.file_we = 1'b1;
      wb.file_wdata = CCI_ZERO_BYTE;
      wb.zero_we = 1'b1;
      wb.zero_val = 1'b1;
      build_fclr = wb;
   endfunction

   function automatic cci_wb_t build_aclr(
      input logic [CCI_ADDR_W-1:0] addr
   );
      cci_wb_t wb;
      wb = '0;
      wb.file_addr = addr;
      wb.acc_we = 1'b1;
      wb.acc_wdata = CCI_ZERO_BYTE;
      wb.zero_we = 1'b1;
      wb.zero_val = 1'b1;
      build_aclr = wb;
   endfunction

   // the file register keeps its value when the result goes to the accumulator
   function automatic cci_wb_t build_fcom(
      input logic [CCI_ADDR_W-1:0] addr,
      input logic dest,
      input logic [CCI_DATA_W-1:0] result,
      input logic result_zero
   );
      cci_wb_t wb;
      wb = '0;
      wb.file_addr = addr;
      if (dest == CCI_DEST_ACC) begin
         wb.acc_we = 1'b1;
         wb.acc_wdata = result;
      end else begin
         wb.file_we = 1'b1;
         wb.file_wdata = result;
      end
      wb.zero_we = 1'b1;
      wb.zero_val = result_zero;
      build_fcom = wb;
   endfunction

   // read address straight off the word so the operand arrives in the same cycle
   assign file_sel = addr_field(INSTR);
   assign FILE_RADDR = file_sel;
   // no forwarding: a complement right after a write to the same register
   // sees the memory as it stands; the core must order such pairs itself
   assign operand = FILE_RDATA;
   assign dest_bit = dest_field(INSTR);

   assign hit_fclr = INSTR_VALID
      && match_masked(INSTR, CCI_FCLR_MASK, CCI_FCLR_PAT);
   assign hit_aclr = INSTR_VALID && match_exact(INSTR, CCI_ACLR_WORD);
   assign hit_fcom = INSTR_VALID
      && match_masked(INSTR, CCI_FCOM_MASK, CCI_FCOM_PAT);
   assign op = encode_op(hit_fclr, hit_aclr, hit_fcom);
   // combinational so the fetch stage never stalls on these words
   assign INSTR_HIT = (op != CCI_OP_NONE);

   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < CCI_DATA_W; bit_idx = bit_idx + 1) begin : g_inv
         assign inverted[bit_idx] = ~operand[bit_idx];
      end
   endgenerate
   assign inv_is_zero = byte_is_zero(inverted);

   assign wb_idle = build_idle(file_sel);
   assign wb_fclr = build_fclr(file_sel);
   assign wb_aclr = build_aclr(file_sel);
   assign wb_fcom = build_fcom(
      file_sel,
      dest_bit,
      inverted,
      inv_is_zero
   );

   always_comb begin
      nxt_wb = wb_idle;
      case (op)
         CCI_OP_FCLR: begin
            nxt_wb = wb_fclr;
         end
         CCI_OP_ACLR: begin
            nxt_wb = wb_aclr;
         end
         CCI_OP_FCOM: begin
            nxt_wb = wb_fcom;
         end
         default: begin
            nxt_wb = wb_idle;
         end
      endcase
   end

   // one registered write-back stage, one cycle per instruction
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         wb_ff <= '0;
      end else begin
         wb_ff <= nxt_wb;
      end
   end

   assign FILE_WE = wb_ff.file_we;
   assign FILE_WADDR = wb_ff.file_addr;
   assign FILE_WDATA = wb_ff.file_wdata;
   assign ACC_WE = wb_ff.acc_we;
   assign ACC_WDATA = wb_ff.acc_wdata;
   assign ZERO_WE = wb_ff.zero_we;
   assign ZERO_VAL = wb_ff.zero_val;
endmodule

// ### rtl/cci_pkg.sv
// constants and carriers for the clear/complement execution block
package cci_pkg;
   localparam int unsigned CCI_DATA_W = 8;
   localparam int unsigned CCI_ADDR_W = 7;
   localparam int unsigned CCI_INSTR_W = 14;
   // opcode patterns and masks (14-bit instruction word)
   localparam logic [13:0] CCI_FCLR_MASK = 14'h3F80;
   localparam logic [13:0] CCI_FCLR_PAT = 14'h0180;
   localparam logic [13:0] CCI_ACLR_WORD = 14'h0103;
   localparam logic [13:0] CCI_FCOM_MASK = 14'h3F00;
   localparam logic [13:0] CCI_FCOM_PAT = 14'h0900;
   localparam int unsigned CCI_DEST_BIT = 7;
   localparam logic [7:0] CCI_ZERO_BYTE = 8'h00;
   localparam logic CCI_DEST_ACC = 1'b0;

   typedef enum logic [1:0] {
      CCI_OP_NONE = 2'b00,
      CCI_OP_FCLR = 2'b01,
      CCI_OP_ACLR = 2'b10,
      CCI_OP_FCOM = 2'b11
   } cci_op_t;

   // result written back by the block
   typedef struct packed {
      logic file_we;
      logic [6:0] file_addr;
      logic [7:0] file_wdata;
      logic acc_we;
      logic [7:0] acc_wdata;
      logic zero_we;
      logic zero_val;
   } cci_wb_t;
endpackage

// ### sim/cci_exec_bench.sv
// random bench for the clear/complement block
`timescale 1ns/1ps
module cci_exec_bench;
   import cci_pkg::*;
   logic clk = 0, rn = 0, v = 0, h, eh = 0, w, a;
   logic [13:0] i = 14'h0000;
   logic [7:0] d = 8'h00, q;
   logic [15:0] r = 16'h001F;
   logic [6:0] ra, fa;
   logic [7:0] fd, ad;
   logic fwe, awe, zwe, zv;
   cci_wb_t s, e = '0;
   int error_cnt = 0, checks = 0, n = 0, k;
   always #50 clk = ~clk;
   cci_exec cci_exec_inst (.CLK(clk), .RESET_N(rn), .INSTR_VALID(v), .INSTR(i),
      .FILE_RDATA(d), .FILE_RADDR(ra), .INSTR_HIT(h), .FILE_WE(fwe), .FILE_WADDR(fa),
      .FILE_WDATA(fd), .ACC_WE(awe), .ACC_WDATA(ad), .ZERO_WE(zwe), .ZERO_VAL(zv));
   assign s = {fwe, fa, fd, awe, ad, zwe, zv};
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input logic [34:0] got, input logic [34:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR wb exp %h got %h", exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) if (++n > 700) begin
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge clk);
      rn <= 1'b1;
      repeat (600) begin
         @(posedge clk);
         k = r % 5;
         r = nx(r);
         v <= k != 4;
         d <= r[3] ? 8'hFF : r[15:8];
         i <= k == 1 ? CCI_ACLR_WORD : k == 2 ? {6'h09, r[7:0]} : k == 3 ? 14'h0064
            : {7'h03, r[6:0]};
         @(negedge clk);
         eh = k < 3;
         chk({h, ra, s}, {eh, i[6:0], e});
         q = ~d;
         w = k == 2 ? i[7] : k == 0;
         a = k == 1 || k == 2 && !i[7];
         e = {w, i[6:0], w && k == 2 ? q : 8'h00, a, a && k == 2 ? q : 8'h00,
            eh, eh && (k < 2 || q == 8'h00)};
      end
      finish_test();
   end
endmodule

// ### sim/cci_exec_monitor.sv
// assertions for the clear/complement block
`timescale 1ns/1ps
module cci_exec_monitor
   import cci_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic INSTR_VALID,
   input wire logic [13:0] INSTR,
   input wire logic [7:0] FILE_RDATA,
   input wire logic [6:0] FILE_RADDR,
   input wire logic INSTR_HIT,
   input wire logic FILE_WE,
   input wire logic [6:0] FILE_WADDR,
   input wire logic [7:0] FILE_WDATA,
   input wire logic ACC_WE,
   input wire logic [7:0] ACC_WDATA,
   input wire logic ZERO_WE,
   input wire logic ZERO_VAL
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   wire fc = INSTR_VALID && (INSTR & CCI_FCLR_MASK) == CCI_FCLR_PAT;
   wire ac = INSTR_VALID && INSTR == CCI_ACLR_WORD;
   wire cm = INSTR_VALID && (INSTR & CCI_FCOM_MASK) == CCI_FCOM_PAT;
   AST_FCLR: assert property (fc |=> FILE_WE && !ACC_WE && ZERO_WE && FILE_WDATA == 8'h00
      && ZERO_VAL) else $error("bad file clear");
   AST_ACLR: assert property (ac |=> ACC_WE && !FILE_WE && ZERO_WE && ACC_WDATA == 8'h00
      && ZERO_VAL) else $error("bad acc clear");
   AST_WADDR: assert property ((fc || cm) |=> FILE_WADDR == $past(INSTR[6:0]))
      else $error("bad write address");
   AST_HIT: assert property (INSTR_HIT == (fc || ac || cm) && FILE_RADDR == INSTR[6:0])
      else $error("bad hit or read address");
   AST_ZERO: assert property (cm |=> ZERO_WE && ZERO_VAL == ($past(FILE_RDATA) == 8'hFF))
      else $error("bad zero flag");
   AST_DEST: assert property (cm |=> FILE_WE == $past(INSTR[7]) && ACC_WE == !FILE_WE
      && (FILE_WE ? FILE_WDATA : ACC_WDATA) == ~$past(FILE_RDATA)) else $error("bad dest");
   AST_ONE: assert property (!(fc || ac || cm) |=> !ZERO_WE && !FILE_WE && !ACC_WE)
      else $error("stray write");
   cover property (fc ##1 cm);
   cover property (cm && FILE_RDATA == 8'hFF);
   cover property (ac ##1 ac);
endmodule
bind cci_exec cci_exec_monitor cci_exec_monitor_inst (
   .CLK(CLK),
   .RESET_N(RESET_N),
   .INSTR_VALID(INSTR_VALID),
   .INSTR(INSTR),
   .FILE_RDATA(FILE_RDATA),
   .FILE_RADDR(FILE_RADDR),
   .INSTR_HIT(INSTR_HIT),
   .FILE_WE(FILE_WE),
   .FILE_WADDR(FILE_WADDR),
   .FILE_WDATA(FILE_WDATA),
   .ACC_WE(ACC_WE),
   .ACC_WDATA(ACC_WDATA),
   .ZERO_WE(ZERO_WE),
   .ZERO_VAL(ZERO_VAL)
);
